// ===== src/operand_address_generator.sv
// operand address generator: register and memory operand resolution
// Notes on behaviour
// [RQ1] byte multiply reads accumulator byte and operand register, writes product to pair
// [RQ2] word divide reads dividend from accumulator pair, writes quotient there
// [RQ3] both decimal adjust forms correct the accumulator byte
// [RQ4] digit rotates left and right hold their digits in the accumulator byte
// [RQ5] register operand comes from flag-selected bank and a 3-bit opcode code
// [RQ6] byte codes map aux, acc, C, B, E, D, L, H; pairs acc, BC, DE, HL
// [RQ7] direct mode uses the 16-bit immediate unchanged as address
// [RQ8] short direct reaches only FE20H..FF1FH by an 8-bit immediate
// [RQ9] short direct bit 8 cleared for 20H..FFH, set for 00H..1FH
// [RQ10] short window: FE20H..FEFFH is fast ram, FF00H..FF1FH special registers
// [RQ11] software gives even addresses for word short direct accesses
// [RQ12] special register mode reaches FF00H..FFCFH and FFE0H..FFFFH by 8-bit immediate
// [RQ13] software names only even, word-capable special registers for word access
// [RQ14] register indirect uses bank DE or HL pair as full address
// [RQ15] decode 0BH load via DE, ABH load via HL plus B, B5H push DE
// [RQ16] based mode adds zero-extended byte offset to HL, carry dropped
// [RQ17] based indexed adds zero-extended B or C to HL, carry dropped
// [RQ18] push, pop, call, return and interrupt saves address through stack pointer
// [RQ19] stack accesses outside fast ram are refused
// [RQ20] short direct forces bits 15..9 high, immediate in bits 7..0
// [RQ21] special register address has upper byte all ones, immediate low
module operand_address_generator
  import operand_address_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic start_i,
  input wire logic decode_opcode_i,
  input wire mode_type mode_i,
  input wire implied_type implied_op_i,
  input wire logic [7:0] opcode_i,
  input wire logic [15:0] imm_i,
  input wire logic [2:0] reg_code_i,
  input wire logic [1:0] pair_code_i,
  input wire logic pair_op_i,
  input wire logic index_c_i,
  input wire logic stack_push_i,
  input wire logic bank_select_low_flag_i,
  input wire logic bank_select_high_flag_i,
  input wire logic [REG_COUNT-1:0][DATA_W-1:0] gp_regs_i,
  input wire logic [15:0] stack_pointer_i,
  output logic done_o,
  output logic [15:0] addr_o,
  output logic addr_valid_o,
  output logic ram_area_o,
  output logic sfr_area_o,
  output logic fault_o,
  output logic reg_valid_o,
  output logic [4:0] src_index_o,
  output logic src_pair_o,
  output logic [4:0] dst_index_o,
  output logic dst_pair_o,
  output logic [4:0] operand_index_o
);

  wire logic [1:0] bank = {bank_select_high_flag_i, bank_select_low_flag_i};

  // [RQ15] fixed opcode decode
  wire logic opc_load_de = decode_opcode_i && (opcode_i == OPC_LOAD_ACC_DE);
  wire logic opc_load_hl_b = decode_opcode_i && (opcode_i == OPC_LOAD_ACC_BASE_B);
  wire logic opc_push_de = decode_opcode_i && (opcode_i == OPC_PUSH_DE);

  wire mode_type eff_mode = opc_load_de ? MODE_REG_INDIRECT :
                            opc_load_hl_b ? MODE_BASED_INDEXED :
                            opc_push_de ? MODE_STACK : mode_i;
  wire logic [1:0] eff_pair = opc_load_de ? PAIR_DE :
                              opc_push_de ? PAIR_DE : pair_code_i;
  wire logic eff_index_c = opc_load_hl_b ? 1'b0 : index_c_i;
  wire logic eff_push = opc_push_de ? 1'b1 : stack_push_i;

  // [RQ6] register slots in the bank
  wire logic [4:0] byte_index = {bank, reg_code_i};
  wire logic [4:0] pair_index = {bank, eff_pair, 1'b0};
  wire logic [4:0] acc_index = {bank, CODE_ACC};
  wire logic [4:0] acc_pair_index = {bank, PAIR_ACC, 1'b0};
  wire logic [4:0] de_low = {bank, PAIR_DE, 1'b0};
  wire logic [4:0] hl_low = {bank, PAIR_BASE, 1'b0};
  wire logic [4:0] index_reg = {bank, (eff_index_c ? CODE_C : CODE_B)};

  wire logic [15:0] de_value = {gp_regs_i[de_low + 5'h01], gp_regs_i[de_low]};
  wire logic [15:0] hl_value = {gp_regs_i[hl_low + 5'h01], gp_regs_i[hl_low]};

  // [RQ14] indirect pair
  wire logic [15:0] indirect_addr = (eff_pair == PAIR_BASE) ? hl_value : de_value;
  // [RQ16] based sum
  wire logic [15:0] based_addr = hl_value + {8'h00, imm_i[7:0]};
  // [RQ17] based indexed sum
  wire logic [15:0] indexed_addr = hl_value + {8'h00, gp_regs_i[index_reg]};
  // [RQ9] short direct bit 8
  wire logic short_bit8 = imm_i[7:0] < SHORT_WRAP_IMM;
  // [RQ20] short direct layout
  wire logic [15:0] short_addr = {SHORT_UPPER, short_bit8, imm_i[7:0]};
  // [RQ21] special register layout
  wire logic [15:0] sfr_addr = {SFR_UPPER, imm_i[7:0]};
  // [RQ12] hole between the two special ranges
  wire logic sfr_hole = (imm_i[7:0] >= SFR_HOLE_LOW) && (imm_i[7:0] <= SFR_HOLE_HIGH);
  // [RQ18] push goes below the pointer, pop and return read at it
  wire logic [15:0] stack_addr = eff_push ? (stack_pointer_i - ONE_WORD) : stack_pointer_i;
  // [RQ19] stack limited to fast ram
  wire logic stack_ok = (stack_addr >= HIGH_RAM_LOW) && (stack_addr <= HIGH_RAM_HIGH);

  logic [15:0] next_addr;
  logic next_addr_valid;
  logic next_fault;
  logic next_reg_valid;
  logic [4:0] next_src;
  logic next_src_pair;
  logic [4:0] next_dst;
  logic next_dst_pair;
  logic [4:0] next_operand;

  // [RQ10] area flags from the resolved address
  wire logic next_ram = next_addr_valid && (next_addr >= HIGH_RAM_LOW)
                        && (next_addr <= HIGH_RAM_HIGH);
  wire logic next_sfr = next_addr_valid && (next_addr >= SFR_LOW);

  always_comb begin
    next_addr = ADDR_RESET;
    next_addr_valid = 1'b0;
    next_fault = 1'b0;
    next_reg_valid = 1'b0;
    next_src = acc_index;
    next_src_pair = 1'b0;
    next_dst = acc_index;
    next_dst_pair = 1'b0;
    next_operand = acc_index;
    case (eff_mode)
      MODE_IMPLIED: begin
        next_reg_valid = 1'b1;
        case (implied_op_i)
          IMPL_UNSIGNED_BYTE_MULTIPLY: begin
            // [RQ1] multiply operands
            next_operand = byte_index;
            next_dst = acc_pair_index;
            next_dst_pair = 1'b1;
          end
          IMPL_UNSIGNED_WORD_DIVIDE: begin
            // [RQ2] divide in accumulator pair
            next_src = acc_pair_index;
            next_src_pair = 1'b1;
            next_dst = acc_pair_index;
            next_dst_pair = 1'b1;
          end
          // [RQ3] decimal adjust on accumulator
          IMPL_DECIMAL_ADJUST_AFTER_ADD, IMPL_DECIMAL_ADJUST_AFTER_SUB: begin
            next_src = acc_index;
          end
          // [RQ4] digit rotate on accumulator
          IMPL_DIGIT_ROTATE_RIGHT, IMPL_DIGIT_ROTATE_LEFT: begin
            next_src = acc_index;
          end
          default: begin
            next_reg_valid = 1'b0;
            next_fault = 1'b1;
          end
        endcase
      end
      MODE_REGISTER: begin
        // [RQ5] bank and code select
        next_reg_valid = 1'b1;
        next_src = pair_op_i ? pair_index : byte_index;
        next_src_pair = pair_op_i;
        next_dst = pair_op_i ? pair_index : byte_index;
        next_dst_pair = pair_op_i;
      end
      MODE_DIRECT: begin
        // [RQ7] immediate address
        next_addr = imm_i;
        next_addr_valid = 1'b1;
      end
      MODE_SHORT_DIRECT: begin
        // [RQ8] fixed window
        next_addr = short_addr;
        next_addr_valid = 1'b1;
      end
      MODE_SPECIAL_REG: begin
        next_addr = sfr_addr;
        next_addr_valid = !sfr_hole;
        next_fault = sfr_hole;
      end
      MODE_REG_INDIRECT: begin
        next_addr = indirect_addr;
        next_addr_valid = 1'b1;
      end
      MODE_BASED: begin
        next_addr = based_addr;
        next_addr_valid = 1'b1;
      end
      MODE_BASED_INDEXED: begin
        next_addr = indexed_addr;
        next_addr_valid = 1'b1;
        next_operand = index_reg;
      end
      MODE_STACK: begin
        next_addr = stack_addr;
        next_addr_valid = stack_ok;
        next_fault = !stack_ok;
        // pair being saved or restored
        next_reg_valid = 1'b1;
        next_src = pair_index;
        next_src_pair = 1'b1;
        next_dst = pair_index;
        next_dst_pair = 1'b1;
      end
      default: begin
        next_fault = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      done_o <= 1'b0;
    end else if (clk_en_i) begin
      done_o <= start_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      addr_o <= ADDR_RESET;
      addr_valid_o <= 1'b0;
      ram_area_o <= 1'b0;
      sfr_area_o <= 1'b0;
      fault_o <= 1'b0;
    end else if (clk_en_i && start_i) begin
      addr_o <= next_addr;
      addr_valid_o <= next_addr_valid;
      ram_area_o <= next_ram;
      sfr_area_o <= next_sfr;
      fault_o <= next_fault;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      reg_valid_o <= 1'b0;
      src_index_o <= 5'h00;
      src_pair_o <= 1'b0;
      dst_index_o <= 5'h00;
      dst_pair_o <= 1'b0;
      operand_index_o <= 5'h00;
    end else if (clk_en_i && start_i) begin
      reg_valid_o <= next_reg_valid;
      src_index_o <= next_src;
      src_pair_o <= next_src_pair;
      dst_index_o <= next_dst;
      dst_pair_o <= next_dst_pair;
      operand_index_o <= next_operand;
    end
  end

  // taken request of a given mode, one enabled edge
  sequence take_mode(mode_type m);
    start_i && clk_en_i && (eff_mode == m);
  endsequence

  chk_short_window: assert property ( // [RQ8]
    @(posedge clk_sys_i) disable iff (reset_i)
    take_mode(MODE_SHORT_DIRECT) |=> addr_valid_o && (addr_o >= SHORT_LOW)
      && (addr_o <= SHORT_HIGH))
    else $error("short direct address left its window");

  chk_short_bit_eight: assert property ( // [RQ9]
    @(posedge clk_sys_i) disable iff (reset_i)
    take_mode(MODE_SHORT_DIRECT) |=> addr_o[8] == ($past(imm_i[7:0]) < SHORT_WRAP_IMM)
      && addr_o[7:0] == $past(imm_i[7:0]) && addr_o[15:9] == SHORT_UPPER)
    else $error("short direct address bits wrong");

  chk_short_area: assert property ( // [RQ10]
    @(posedge clk_sys_i) disable iff (reset_i)
    take_mode(MODE_SHORT_DIRECT) |=> (sfr_area_o == addr_o[8]) && (ram_area_o != addr_o[8]))
    else $error("short direct area flag wrong");

  chk_direct_pass: assert property ( // [RQ7]
    @(posedge clk_sys_i) disable iff (reset_i)
    take_mode(MODE_DIRECT) |=> addr_valid_o && addr_o == $past(imm_i))
    else $error("direct address altered");

  chk_special_hole: assert property ( // [RQ12]
    @(posedge clk_sys_i) disable iff (reset_i)
    take_mode(MODE_SPECIAL_REG) |=> (addr_o[15:8] == SFR_UPPER)
      && (fault_o == ((addr_o[7:0] >= SFR_HOLE_LOW) && (addr_o[7:0] <= SFR_HOLE_HIGH)))
      && (addr_valid_o != fault_o))
    else $error("special register address or hole wrong");

  chk_based_sum: assert property ( // [RQ16]
    @(posedge clk_sys_i) disable iff (reset_i)
    take_mode(MODE_BASED) |=> addr_o == 16'($past(hl_value) + {8'h00, $past(imm_i[7:0])}))
    else $error("based address sum wrong");

  chk_indexed_sum: assert property ( // [RQ17]
    @(posedge clk_sys_i) disable iff (reset_i)
    take_mode(MODE_BASED_INDEXED) |=> addr_o == 16'($past(hl_value)
      + {8'h00, $past(gp_regs_i[index_reg])}))
    else $error("based indexed sum wrong");

  chk_stack_ram: assert property ( // [RQ19]
    @(posedge clk_sys_i) disable iff (reset_i)
    take_mode(MODE_STACK) |=> (addr_valid_o != fault_o) && (!addr_valid_o || ram_area_o))
    else $error("stack access outside fast ram");

  chk_push_decode: assert property ( // [RQ15]
    @(posedge clk_sys_i) disable iff (reset_i)
    start_i && clk_en_i && opc_push_de |=> src_pair_o && src_index_o[2:1] == PAIR_DE)
    else $error("push opcode pair wrong");

  chk_divide_pair: assert property ( // [RQ2]
    @(posedge clk_sys_i) disable iff (reset_i)
    take_mode(MODE_IMPLIED) ##0 implied_op_i == IMPL_UNSIGNED_WORD_DIVIDE
      |=> src_pair_o && dst_pair_o && dst_index_o[2:1] == PAIR_ACC && reg_valid_o)
    else $error("divide not on accumulator pair");

  chk_done_pulse: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    start_i && clk_en_i ##1 clk_en_i && !start_i |=> !done_o)
    else $error("done held too long");

  // taken request with no opcode override
  sequence take_plain(mode_type m);
    take_mode(m) ##0 !decode_opcode_i;
  endsequence

  chk_multiply_regs: assert property ( // [RQ1]
    @(posedge clk_sys_i) disable iff (reset_i)
    take_mode(MODE_IMPLIED) ##0 implied_op_i == IMPL_UNSIGNED_BYTE_MULTIPLY
      |=> !src_pair_o && src_index_o[2:0] == CODE_ACC && dst_pair_o
      && dst_index_o[2:1] == PAIR_ACC && operand_index_o[2:0] == $past(reg_code_i))
    else $error("multiply operands wrong");

  chk_register_select: assert property ( // [RQ5]
    @(posedge clk_sys_i) disable iff (reset_i)
    take_plain(MODE_REGISTER) ##0 !pair_op_i |=> reg_valid_o && !src_pair_o
      && src_index_o == {$past(bank_select_high_flag_i), $past(bank_select_low_flag_i),
      $past(reg_code_i)})
    else $error("register operand slot wrong");

  chk_indirect_pair: assert property ( // [RQ14]
    @(posedge clk_sys_i) disable iff (reset_i)
    take_plain(MODE_REG_INDIRECT) |=> addr_valid_o
      && addr_o == (($past(pair_code_i) == PAIR_BASE) ? $past(hl_value) : $past(de_value)))
    else $error("indirect address not from pair");

  chk_stack_pointer: assert property ( // [RQ18]
    @(posedge clk_sys_i) disable iff (reset_i)
    take_plain(MODE_STACK) |=> addr_o == ($past(stack_push_i)
      ? 16'($past(stack_pointer_i) - ONE_WORD) : $past(stack_pointer_i)))
    else $error("stack address not from pointer");

endmodule // operand_address_generator

// ===== inc/operand_address_pkg.sv
// constants and types shared by the operand address generator
package operand_address_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned REG_COUNT = 32;

  // byte register codes
  localparam logic [2:0] CODE_AUX = 3'h0;
  localparam logic [2:0] CODE_ACC = 3'h1;
  localparam logic [2:0] CODE_C = 3'h2;
  localparam logic [2:0] CODE_B = 3'h3;
  localparam logic [2:0] CODE_E = 3'h4;
  localparam logic [2:0] CODE_D = 3'h5;
  localparam logic [2:0] CODE_L = 3'h6;
  localparam logic [2:0] CODE_H = 3'h7;

  // pair codes
  localparam logic [1:0] PAIR_ACC = 2'h0;
  localparam logic [1:0] PAIR_BC = 2'h1;
  localparam logic [1:0] PAIR_DE = 2'h2;
  localparam logic [1:0] PAIR_BASE = 2'h3;

  // fixed opcode bytes
  localparam logic [7:0] OPC_LOAD_ACC_DE = 8'h0B;
  localparam logic [7:0] OPC_LOAD_ACC_BASE_B = 8'hAB;
  localparam logic [7:0] OPC_PUSH_DE = 8'hB5;

  // short direct window
  localparam logic [15:0] SHORT_LOW = 16'hFE20;
  localparam logic [15:0] SHORT_HIGH = 16'hFF1F;
  localparam logic [7:0] SHORT_WRAP_IMM = 8'h20;
  localparam logic [6:0] SHORT_UPPER = 7'h7F;

  // special register space
  localparam logic [15:0] SFR_LOW = 16'hFF00;
  localparam logic [7:0] SFR_UPPER = 8'hFF;
  localparam logic [7:0] SFR_HOLE_LOW = 8'hD0;
  localparam logic [7:0] SFR_HOLE_HIGH = 8'hDF;

  // internal high-speed ram
  localparam logic [15:0] HIGH_RAM_LOW = 16'hFB00;
  localparam logic [15:0] HIGH_RAM_HIGH = 16'hFEFF;

  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [15:0] ONE_WORD = 16'h0001;

  typedef enum logic [8:0] {
    MODE_IMPLIED = 9'h001,
    MODE_REGISTER = 9'h002,
    MODE_DIRECT = 9'h004,
    MODE_SHORT_DIRECT = 9'h008,
    MODE_SPECIAL_REG = 9'h010,
    MODE_REG_INDIRECT = 9'h020,
    MODE_BASED = 9'h040,
    MODE_BASED_INDEXED = 9'h080,
    MODE_STACK = 9'h100
  } mode_type;

  typedef enum logic [5:0] {
    IMPL_UNSIGNED_BYTE_MULTIPLY = 6'h01,
    IMPL_UNSIGNED_WORD_DIVIDE = 6'h02,
    IMPL_DECIMAL_ADJUST_AFTER_ADD = 6'h04,
    IMPL_DECIMAL_ADJUST_AFTER_SUB = 6'h08,
    IMPL_DIGIT_ROTATE_RIGHT = 6'h10,
    IMPL_DIGIT_ROTATE_LEFT = 6'h20
  } implied_type;

endpackage

// ===== verification/operand_address_generator_tb.sv
// self-checking bench for the operand address generator
module operand_address_generator_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import operand_address_pkg::*;

  logic clk_sys_i, reset_i, clk_en_i, start_i, decode_opcode_i;
  mode_type mode_i;
  implied_type implied_op_i;
  logic [7:0] opcode_i;
  logic [15:0] imm_i, stack_pointer_i;
  logic [2:0] reg_code_i;
  logic [1:0] pair_code_i, bank;
  logic pair_op_i, index_c_i, stack_push_i;
  logic bank_select_low_flag_i, bank_select_high_flag_i;
  logic [REG_COUNT-1:0][DATA_W-1:0] gp_regs_i;
  logic done_o, addr_valid_o, ram_area_o, sfr_area_o, fault_o, reg_valid_o;
  logic src_pair_o, dst_pair_o;
  logic [15:0] addr_o;
  logic [4:0] src_index_o, dst_index_o, operand_index_o;
  int n_errors = 0;
  int cmp_count = 0;

  assign bank_select_low_flag_i = bank[0];
  assign bank_select_high_flag_i = bank[1];

  operand_address_generator DUT (.clk_sys_i, .reset_i, .clk_en_i, .start_i,
    .decode_opcode_i, .mode_i, .implied_op_i, .opcode_i, .imm_i, .reg_code_i,
    .pair_code_i, .pair_op_i, .index_c_i, .stack_push_i, .bank_select_low_flag_i,
    .bank_select_high_flag_i, .gp_regs_i, .stack_pointer_i, .done_o, .addr_o,
    .addr_valid_o, .ram_area_o, .sfr_area_o, .fault_o, .reg_valid_o, .src_index_o,
    .src_pair_o, .dst_index_o, .dst_pair_o, .operand_index_o);

  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // one request, done pulse for one cycle
  task automatic go(input mode_type m);
    mode_i = m;
    start_i = 1'b1;
    @(negedge clk_sys_i);
    start_i = 1'b0;
    chk(16'(done_o), 16'h0001);
    @(negedge clk_sys_i);
    chk(16'(done_o), 16'h0000);
  endtask

  function automatic logic [15:0] pr(input logic [1:0] b, input logic [1:0] p);
    return {gp_regs_i[{b, p, 1'b1}], gp_regs_i[{b, p, 1'b0}]};
  endfunction

  task automatic t_implied;
    for (int i = 0; i < 6; i++) begin
      bank = 2'(i);
      reg_code_i = 3'(7 - i);
      implied_op_i = implied_type'(6'h01 << i);
      go(MODE_IMPLIED);
      chk(16'(reg_valid_o), 16'h0001);
      chk(16'(fault_o), 16'h0000);
      chk(16'(src_index_o), 16'({bank, (i == 1) ? 3'h0 : 3'h1}));
      chk(16'(dst_index_o), 16'({bank, (i < 2) ? 3'h0 : 3'h1}));
      chk(16'(src_pair_o), 16'(i == 1));
      chk(16'(dst_pair_o), 16'(i < 2));
      if (i == 0) begin
        chk(16'(operand_index_o), 16'({bank, reg_code_i}));
      end
    end
    // illegal implied operation is flagged
    implied_op_i = implied_type'(6'h03);
    go(MODE_IMPLIED);
    chk(16'(fault_o), 16'h0001);
    chk(16'(reg_valid_o), 16'h0000);
    $display("implied test done");
  endtask

  task automatic t_register;
    logic [4:0] e;
    for (int b = 0; b < 4; b++) begin
      bank = 2'(b);
      for (int c = 0; c < 12; c++) begin
        pair_op_i = (c >= 8);
        reg_code_i = 3'(c);
        pair_code_i = 2'(c - 8);
        go(MODE_REGISTER);
        e = pair_op_i ? {bank, pair_code_i, 1'b0} : {bank, reg_code_i};
        chk(16'(src_index_o), 16'(e));
        chk(16'(dst_index_o), 16'(e));
        chk(16'(src_pair_o), 16'(pair_op_i));
        chk(16'(dst_pair_o), 16'(pair_op_i));
        chk(16'(reg_valid_o), 16'h0001);
      end
    end
    pair_op_i = 1'b0;
    $display("register test done");
  endtask

  task automatic t_direct;
    logic [15:0] d[4] = '{16'h1234, 16'hFEFF, 16'hFF00, 16'hFAFF};
    logic [7:0] s[5] = '{8'h00, 8'h1F, 8'h20, 8'h30, 8'hFF};
    for (int i = 0; i < 4; i++) begin
      imm_i = d[i];
      go(MODE_DIRECT);
      chk(addr_o, d[i]);
      chk(16'(addr_valid_o), 16'h0001);
      chk(16'(ram_area_o), 16'(d[i] >= HIGH_RAM_LOW && d[i] <= HIGH_RAM_HIGH));
      chk(16'(sfr_area_o), 16'(d[i] >= SFR_LOW));
    end
    for (int i = 0; i < 5; i++) begin
      imm_i = {8'hAB, s[i]};
      go(MODE_SHORT_DIRECT);
      chk(addr_o, {7'h7F, s[i] < 8'h20, s[i]});
      chk(16'(ram_area_o), 16'(s[i] >= 8'h20));
      chk(16'(sfr_area_o), 16'(s[i] < 8'h20));
    end
    // word access at an even short address
    imm_i = 16'h0022;
    go(MODE_SHORT_DIRECT);
    chk(addr_o, 16'hFE22);
    $display("direct test done");
  endtask

  task automatic t_sfr;
    logic [7:0] s[6] = '{8'h00, 8'hCF, 8'hD0, 8'hDF, 8'hE0, 8'hFF};
    logic hole;
    for (int i = 0; i < 6; i++) begin
      imm_i = {8'h5A, s[i]};
      hole = (s[i] >= 8'hD0 && s[i] <= 8'hDF);
      go(MODE_SPECIAL_REG);
      chk(16'(fault_o), 16'(hole));
      chk(16'(addr_valid_o), 16'(!hole));
      if (!hole) begin
        chk(addr_o, {8'hFF, s[i]});
      end
    end
    // word special register at an even address
    imm_i = 16'h00E2;
    go(MODE_SPECIAL_REG);
    chk(addr_o, 16'hFFE2);
    $display("special register test done");
  endtask

  task automatic t_memory;
    logic [15:0] hl, de, bb, cc;
    for (int b = 0; b < 4; b++) begin
      bank = 2'(b);
      hl = pr(bank, PAIR_BASE);
      de = pr(bank, PAIR_DE);
      bb = {8'h00, gp_regs_i[{bank, CODE_B}]};
      cc = {8'h00, gp_regs_i[{bank, CODE_C}]};
      pair_code_i = PAIR_BASE;
      go(MODE_REG_INDIRECT);
      chk(addr_o, hl);
      pair_code_i = PAIR_DE;
      go(MODE_REG_INDIRECT);
      chk(addr_o, de);
      imm_i = 16'hC390;
      go(MODE_BASED);
      chk(addr_o, hl + 16'h0090);
      index_c_i = 1'b0;
      go(MODE_BASED_INDEXED);
      chk(addr_o, hl + bb);
      index_c_i = 1'b1;
      go(MODE_BASED_INDEXED);
      chk(addr_o, hl + cc);
      decode_opcode_i = 1'b1;
      opcode_i = OPC_LOAD_ACC_DE;
      go(MODE_DIRECT);
      chk(addr_o, de);
      opcode_i = OPC_LOAD_ACC_BASE_B;
      go(MODE_DIRECT);
      chk(addr_o, hl + bb);
      opcode_i = OPC_PUSH_DE;
      stack_pointer_i = 16'hFE10;
      stack_push_i = 1'b0;
      go(MODE_DIRECT);
      chk(addr_o, 16'hFE0F);
      decode_opcode_i = 1'b0;
    end
    $display("memory test done");
  endtask

  task automatic t_stack;
    logic [15:0] sp[6] = '{16'hFE00, 16'hFE00, 16'hFF00, 16'hFB00, 16'hFB00, 16'hFEFF};
    logic [15:0] a;
    logic ok;
    for (int i = 0; i < 6; i++) begin
      stack_push_i = (i == 0 || i == 3);
      stack_pointer_i = sp[i];
      a = stack_push_i ? sp[i] - 16'h0001 : sp[i];
      ok = (a >= HIGH_RAM_LOW && a <= HIGH_RAM_HIGH);
      go(MODE_STACK);
      chk(16'(fault_o), 16'(!ok));
      chk(16'(addr_valid_o), 16'(ok));
      if (ok) begin
        chk(addr_o, a);
      end
    end
    $display("stack test done");
  endtask

  // enable low freezes outputs
  task automatic t_hold;
    logic [15:0] prev;
    prev = addr_o;
    clk_en_i = 1'b0;
    imm_i = 16'h4321;
    mode_i = MODE_DIRECT;
    start_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    chk(16'(done_o), 16'h0000);
    chk(addr_o, prev);
    clk_en_i = 1'b1;
    go(MODE_DIRECT);
    chk(addr_o, 16'h4321);
    $display("hold test done");
  endtask

  initial begin
    {reset_i, clk_en_i, start_i, decode_opcode_i, pair_op_i, index_c_i} = 6'h30;
    {stack_push_i, bank, reg_code_i, pair_code_i} = 8'h00;
    mode_i = MODE_IMPLIED;
    implied_op_i = IMPL_UNSIGNED_BYTE_MULTIPLY;
    opcode_i = 8'h00;
    imm_i = 16'h0000;
    stack_pointer_i = 16'hFE00;
    for (int i = 0; i < 32; i++) begin
      gp_regs_i[i] = 8'(i * 37 + 11);
    end
    gp_regs_i[{2'h2, CODE_H}] = 8'hFF;
    gp_regs_i[{2'h2, CODE_L}] = 8'hF0;
    gp_regs_i[{2'h2, CODE_B}] = 8'hF0;
    repeat (6) @(negedge clk_sys_i);
    reset_i = 1'b0;
    chk(16'(done_o), 16'h0000);
    chk(addr_o, ADDR_RESET);
    t_implied();
    t_register();
    t_direct();
    t_sfr();
    t_memory();
    t_stack();
    t_hold();
    finish_test();
  end

  initial begin
    #100000;
    n_errors++;
    $display("wrong value at %0t: run hung", $time);
    finish_test();
  end
endmodule // operand_address_generator_tb
